// *** src/sds_regs.vh ***
// Constants shared by the sensor display scanner files
`ifndef SDS_REGS_VH
`define SDS_REGS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SDS_CLK_MHZ          100
`define SDS_BASE_TICK_US     32768
`define SDS_SCAN_US          2048
`define SDS_SAMPLE_US        491520
`define SDS_SAMPLE_TICKS     (`SDS_SAMPLE_US / `SDS_BASE_TICK_US)
`define SDS_BASE_CNT_W       22
`define SDS_SCAN_CNT_W       18
`define SDS_TICK_CNT_W       4
`define SDS_CNT_ONE_BASE     22'h000001
`define SDS_CNT_ONE_SCAN     18'h00001
`define SDS_CNT_ONE_TICK     4'h1

// ****************************************************************
// Converter access
// ****************************************************************
`define SDS_CHANNEL_ZERO     3'h0
`define SDS_CODE_SHIFT       6
`define SDS_CODE_MASK        16'h03ff

// ****************************************************************
// Tenths of kPa: floor((10000*code + 971850) / 9207)
// ****************************************************************
`define SDS_SCALE            14'h2710
`define SDS_OFFSET           24'h0ed44a
`define SDS_DIVISOR          14'h23f7
`define SDS_DIV_STEPS        5'h18
`define SDS_DIV_ONE          5'h01
`define SDS_TEN              11'h00a
`define SDS_HUNDRED          11'h064
`define SDS_THOUSAND         11'h3e8

// ****************************************************************
// Display layout and segment patterns (bit 7 is the decimal point)
// ****************************************************************
`define SDS_LAST_DIGIT       2'h3
`define SDS_FIRST_DIGIT      2'h0
`define SDS_DIGIT_ONE        2'h1
`define SDS_POINT_DIGIT      2'h1
`define SDS_SEG_POINT        8'h80
`define SDS_SEG_BLANK        8'h00
`define SDS_SEG_0            8'h3f
`define SDS_SEG_1            8'h06
`define SDS_SEG_2            8'h5b
`define SDS_SEG_3            8'h4f
`define SDS_SEG_4            8'h66
`define SDS_SEG_5            8'h6d
`define SDS_SEG_6            8'h7d
`define SDS_SEG_7            8'h27
`define SDS_SEG_8            8'h7f
`define SDS_SEG_9            8'h6f

`endif

// *** src/sds_seg_encode.v ***
// Decimal digit to seven-segment pattern encoder
`timescale 1ns/1ns
`include "sds_regs.vh"

module sds_seg_encode (
  input  wire [3:0] digit_i,    // Decimal digit 0..9
  input  wire       point_i,    // Light the decimal point too
  input  wire       blank_i,    // Suppress the digit (leading zero)
  output reg  [7:0] pattern_o   // Active-high segment pattern
);

  reg [7:0] glyph;

  always @* begin
    case (digit_i)
      4'h0: glyph = `SDS_SEG_0; // see RULE9
      4'h1: glyph = `SDS_SEG_1;
      4'h2: glyph = `SDS_SEG_2;
      4'h3: glyph = `SDS_SEG_3;
      4'h4: glyph = `SDS_SEG_4;
      4'h5: glyph = `SDS_SEG_5;
      4'h6: glyph = `SDS_SEG_6;
      4'h7: glyph = `SDS_SEG_7;
      4'h8: glyph = `SDS_SEG_8;
      4'h9: glyph = `SDS_SEG_9;
      default: glyph = `SDS_SEG_BLANK;
    endcase
    if (blank_i) begin
      pattern_o = `SDS_SEG_BLANK;
    end else if (point_i) begin
      pattern_o = glyph | `SDS_SEG_POINT; // see RULE10 see RULE16
    end else begin
      pattern_o = glyph;
    end
  end

endmodule

// *** src/sds_scanner.v ***
// Periodic sensor sampling and four-digit multiplexed display scanner
//
// Operation
// RULE1 - Free-running base tick every 32.768 ms
// RULE2 - Start conversion every 0.49152 s, poll at ticks
// RULE3 - No completion interrupt; poll on tick flag
// RULE4 - Sample only analog channel zero
// RULE5 - One digit lit; advance every 2.048 ms
// RULE6 - Scan from rightmost digit to fourth
// RULE7 - Digit number on two select outputs
// RULE8 - Eight active-high segment outputs
// RULE9 - Fixed patterns for decimal digits zero to nine
// RULE10 - Lowest integer digit ORed with decimal point
// RULE11 - Result becomes four digits of display data
// RULE12 - Sampling clears tick flag, fills display buffer
// RULE13 - Scan clears flag, shows next buffered digit
// RULE14 - Result is left-aligned: shift six, mask
// RULE15 - Display tenths of kPa, fraction dropped
// RULE16 - Decimal point is segment bit seven
// RULE17 - Digit index counts 0..3, zero after reset
`timescale 1ns/1ns
`include "sds_regs.vh"

module sds_scanner #(
  parameter [31:0] BASE_TICK_CYCLES = `SDS_BASE_TICK_US * `SDS_CLK_MHZ, // Cycles per base tick
  parameter [31:0] SCAN_CYCLES      = `SDS_SCAN_US * `SDS_CLK_MHZ       // Cycles per digit slot
) (
  input  wire        clock_i,             // 100 MHz system clock
  input  wire        srst_i,              // Synchronous reset, active high
  input  wire        conv_done_i,         // Converter result ready (level)
  input  wire [15:0] conversion_result_i, // Left-aligned 10-bit result
  output reg         conv_start_o,        // One-cycle conversion start pulse
  output reg  [2:0]  conv_channel_o,      // Analog channel select
  output reg  [10:0] display_value_o,     // Last value shown, tenths of kPa
  output reg         digit_select_bit0_o, // Digit select, low bit
  output reg         digit_select_bit1_o, // Digit select, high bit
  output reg  [7:0]  segment_line_o       // Segments, bit 0 low line .. bit 7 high line
);

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam [`SDS_BASE_CNT_W-1:0] BASE_LAST    = BASE_TICK_CYCLES[`SDS_BASE_CNT_W-1:0] - `SDS_CNT_ONE_BASE;
  localparam [`SDS_SCAN_CNT_W-1:0] SCAN_LAST    = SCAN_CYCLES[`SDS_SCAN_CNT_W-1:0] - `SDS_CNT_ONE_SCAN;
  localparam [31:0]                SAMPLE_TICKS = `SDS_SAMPLE_TICKS;
  localparam [`SDS_TICK_CNT_W-1:0] TICK_LAST    = SAMPLE_TICKS[`SDS_TICK_CNT_W-1:0] - `SDS_CNT_ONE_TICK;

  // One-hot sequencer states
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_CONV  = 4'h2;
  localparam [3:0] ST_DIV   = 4'h4;
  localparam [3:0] ST_STORE = 4'h8;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Decimal digit of a value at a given place (0 = tenths)
  function [3:0] digit_of;
    input [10:0] value;
    input [1:0]  place;
    reg   [10:0] part;
    begin
      part = 11'h000;
      case (place)
        2'h0:    part = value % `SDS_TEN;
        2'h1:    part = (value / `SDS_TEN) % `SDS_TEN;
        2'h2:    part = (value / `SDS_HUNDRED) % `SDS_TEN;
        default: part = value / `SDS_THOUSAND;
      endcase
      digit_of = part[3:0];
    end
  endfunction

  // Leading zeros above the units place stay dark
  function blank_of;
    input [10:0] value;
    input [1:0]  place;
    begin
      case (place)
        2'h2:    blank_of = (value < `SDS_HUNDRED);
        2'h3:    blank_of = (value < `SDS_THOUSAND);
        default: blank_of = 1'b0;
      endcase
    end
  endfunction

  // Ten-bit code from the left-aligned converter word
  function [9:0] code_of;
    input [15:0] word;
    reg   [15:0] shifted;
    begin
      shifted = (word >> `SDS_CODE_SHIFT) & `SDS_CODE_MASK; // see RULE14
      code_of = shifted[9:0];
    end
  endfunction

  // Dividend of the tenths-of-kPa quotient; widened so no product bit is lost
  function [23:0] dividend_of;
    input [9:0] value;
    begin
      dividend_of = {14'h0000, value} * {10'h000, `SDS_SCALE} + `SDS_OFFSET; // see RULE15
    end
  endfunction

  // Two-bit digit index, wrapping from the fourth digit back to the first
  function [1:0] next_index;
    input [1:0] index;
    begin
      next_index = index + `SDS_DIGIT_ONE; // see RULE17
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [`SDS_BASE_CNT_W-1:0] base_cnt;
  reg                       tick_flag;
  reg [`SDS_TICK_CNT_W-1:0] tick_cnt;
  reg [`SDS_SCAN_CNT_W-1:0] scan_cnt;
  reg                       scan_flag;
  reg [1:0]                 digit_idx;
  reg [3:0]                 state;
  reg [23:0]                dividend;
  reg [14:0]                remainder;
  reg [23:0]                quotient;
  reg [4:0]                 div_left;
  reg [1:0]                 store_idx;
  reg [7:0]                 disp_buf [0:3];

  // ****************************************************************
  // Timer decode and divider datapath
  // ****************************************************************
  wire                      base_ovf = (base_cnt == BASE_LAST);
  wire                      scan_ovf = (scan_cnt == SCAN_LAST);
  wire                      sample_due = tick_flag && (tick_cnt == TICK_LAST);
  wire [9:0]                code = code_of(conversion_result_i);
  wire                      poll_take = tick_flag && conv_done_i;
  wire [14:0]               trial = {remainder[13:0], dividend[23]};
  wire                      fits = (trial >= {1'b0, `SDS_DIVISOR});
  wire [14:0]               trial_sub = trial - {1'b0, `SDS_DIVISOR};
  wire [10:0]               result_value = quotient[10:0];
  wire [1:0]                next_digit = next_index(digit_idx);
  wire [7:0]                store_pattern;
  reg                       tick_service;
  reg                       scan_service;

  // ****************************************************************
  // Base tick timer
  // ****************************************************************
  always @(posedge clock_i) begin
    if (srst_i) begin
      base_cnt <= {`SDS_BASE_CNT_W{1'b0}};
      tick_flag <= 1'b0;
    end else begin
      // Free-running: only reset restarts the pacing count
      if (base_ovf) begin
        base_cnt <= {`SDS_BASE_CNT_W{1'b0}}; // see RULE1
      end else begin
        base_cnt <= base_cnt + `SDS_CNT_ONE_BASE;
      end
      // Set wins: a new overflow in the service cycle is kept, not lost
      if (base_ovf) begin
        tick_flag <= 1'b1; // see RULE3
      end else if (tick_service) begin
        tick_flag <= 1'b0; // see RULE12
      end
    end
  end

  always @* begin
    tick_service = tick_flag;
  end

  // ****************************************************************
  // Sampling sequencer
  // ****************************************************************
  always @(posedge clock_i) begin
    if (srst_i) begin
      tick_cnt <= {`SDS_TICK_CNT_W{1'b0}};
      state <= ST_IDLE;
      conv_start_o <= 1'b0;
      conv_channel_o <= `SDS_CHANNEL_ZERO;
      dividend <= 24'h000000;
      remainder <= 15'h0000;
      quotient <= 24'h000000;
      div_left <= 5'h00;
      store_idx <= `SDS_FIRST_DIGIT;
      display_value_o <= 11'h000;
    end else begin
      conv_start_o <= 1'b0;
      conv_channel_o <= `SDS_CHANNEL_ZERO; // see RULE4
      if (tick_flag) begin
        if (tick_cnt == TICK_LAST) begin
          tick_cnt <= {`SDS_TICK_CNT_W{1'b0}};
        end else begin
          tick_cnt <= tick_cnt + `SDS_CNT_ONE_TICK; // see RULE2
        end
      end
      case (state)
        ST_IDLE: begin
          // A start that comes due while busy is skipped, not queued
          if (sample_due) begin
            conv_start_o <= 1'b1; // see RULE2
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          // Completion is looked at only on tick instants
          if (poll_take) begin // see RULE3
            dividend <= dividend_of(code); // see RULE14 see RULE15
            remainder <= 15'h0000;
            quotient <= 24'h000000;
            div_left <= `SDS_DIV_STEPS;
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          // Restoring division keeps the datapath to one subtractor
          dividend <= {dividend[22:0], 1'b0};
          remainder <= fits ? trial_sub : trial; // see RULE15
          quotient <= {quotient[22:0], fits};
          div_left <= div_left - `SDS_DIV_ONE;
          if (div_left == `SDS_DIV_ONE) begin
            store_idx <= `SDS_FIRST_DIGIT;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          // Value and the last pattern land in the same cycle
          if (store_idx == `SDS_LAST_DIGIT) begin
            display_value_o <= result_value;
            state <= ST_IDLE;
          end
          store_idx <= next_index(store_idx);
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Display buffer fill, one digit per cycle
  // ****************************************************************
  sds_seg_encode u_encode (
    .digit_i   (digit_of(result_value, store_idx)),           // see RULE11
    .point_i   (store_idx == `SDS_POINT_DIGIT),               // see RULE10
    .blank_i   (blank_of(result_value, store_idx)),
    .pattern_o (store_pattern)
  );

  always @(posedge clock_i) begin
    if (srst_i) begin
      disp_buf[0] <= `SDS_SEG_BLANK;
      disp_buf[1] <= `SDS_SEG_BLANK;
      disp_buf[2] <= `SDS_SEG_BLANK;
      disp_buf[3] <= `SDS_SEG_BLANK;
    end else if (state == ST_STORE) begin
      disp_buf[store_idx] <= store_pattern; // see RULE12
    end
  end

  // ****************************************************************
  // Digit scanner
  // ****************************************************************
  always @* begin
    scan_service = scan_flag;
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      scan_cnt <= {`SDS_SCAN_CNT_W{1'b0}};
      scan_flag <= 1'b0;
      digit_idx <= `SDS_FIRST_DIGIT; // see RULE17
      digit_select_bit0_o <= 1'b0;
      digit_select_bit1_o <= 1'b0;
      segment_line_o <= `SDS_SEG_BLANK;
    end else begin
      if (scan_ovf) begin
        scan_cnt <= {`SDS_SCAN_CNT_W{1'b0}}; // see RULE5
      end else begin
        scan_cnt <= scan_cnt + `SDS_CNT_ONE_SCAN;
      end
      // Set wins here too, so no digit slot is ever dropped
      if (scan_ovf) begin
        scan_flag <= 1'b1;
      end else if (scan_service) begin
        scan_flag <= 1'b0; // see RULE13
      end
      if (scan_service) begin
        // Two-bit index wraps from the fourth digit back to the first
        digit_idx <= next_digit; // see RULE6 see RULE17
        digit_select_bit0_o <= next_digit[0]; // see RULE7
        digit_select_bit1_o <= next_digit[1];
        segment_line_o <= disp_buf[next_digit]; // see RULE8 see RULE13
      end else begin
        // Mid-slot buffer refreshes show after one cycle
        segment_line_o <= disp_buf[digit_idx]; // see RULE5
      end
    end
  end

endmodule

// *** tb/sds_scanner_props.sv ***
// Assertion checker for the sensor display scanner
`timescale 1ns/1ns
module sds_scanner_props #(
  parameter [31:0] BASE_TICK_CYCLES = 32'd3276800, // Cycles per base tick
  parameter [31:0] SCAN_CYCLES      = 32'd204800   // Cycles per digit slot
) (
  input wire logic        clock_i,             // System clock
  input wire logic        srst_i,              // Synchronous reset
  input wire logic        conv_done_i,         // Converter ready
  input wire logic [15:0] conversion_result_i, // Converter result
  input wire logic        conv_start_o,        // Start pulse
  input wire logic [2:0]  conv_channel_o,      // Channel select
  input wire logic [10:0] display_value_o,     // Shown value
  input wire logic        digit_select_bit0_o, // Select low bit
  input wire logic        digit_select_bit1_o, // Select high bit
  input wire logic [7:0]  segment_line_o       // Segments
);
  // ****************************************************************
  // Gap counters between scan steps and between starts
  // ****************************************************************
  logic [1:0]  sel;
  logic [1:0]  sel_q;
  logic [31:0] scan_gap;
  logic [31:0] start_gap;
  logic        scan_seen;
  logic        start_seen;
  // A result is taken on a tick, then 24 divide and 4 store cycles pass
  localparam logic [31:0] TAKE_LAG = 32'd28;
  assign sel = {digit_select_bit1_o, digit_select_bit0_o};
  always @(posedge clock_i) begin
    if (srst_i) begin
      sel_q      <= 2'h0;
      scan_gap   <= 32'h0;
      start_gap  <= 32'h0;
      scan_seen  <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      sel_q      <= sel;
      scan_gap   <= (sel != sel_q) ? 32'h1 : scan_gap + 32'h1;
      start_gap  <= conv_start_o ? 32'h1 : start_gap + 32'h1;
      scan_seen  <= scan_seen | (sel != sel_q);
      start_seen <= start_seen | conv_start_o;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    conv_start_o;
  endsequence
  sequence s_step;
    sel != sel_q;
  endsequence
  property p_start_pulse;
    s_start |=> !conv_start_o;
  endproperty
  property p_sample_period;
    s_start and start_seen |-> start_gap == 32'd15 * BASE_TICK_CYCLES;
  endproperty
  property p_no_instant_take;
    $changed(display_value_o) |-> start_seen && (start_gap % BASE_TICK_CYCLES) == TAKE_LAG;
  endproperty
  property p_channel;
    conv_channel_o == 3'h0;
  endproperty
  property p_sel_step;
    s_step |-> sel == sel_q + 2'h1;
  endproperty
  property p_scan_period;
    s_step and scan_seen |-> scan_gap == SCAN_CYCLES;
  endproperty
  property p_point_digit;
    segment_line_o[7] |-> sel == 2'h1;
  endproperty
  property p_legal_pattern;
    segment_line_o[6:0] inside {7'h00, 7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h27, 7'h7f, 7'h6f};
  endproperty
  property p_reset_state;
    $fell(srst_i) |-> sel == 2'h0 && segment_line_o == 8'h00 && !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  a_sample_period: assert property (p_sample_period) else $error("sample period wrong");
  a_no_instant_take: assert property (p_no_instant_take) else $error("value taken off a tick");
  a_channel: assert property (p_channel) else $error("channel not zero");
  a_sel_step: assert property (p_sel_step) else $error("digit order wrong");
  a_scan_period: assert property (p_scan_period) else $error("scan period wrong");
  a_point_digit: assert property (p_point_digit) else $error("point on wrong digit");
  a_legal_pattern: assert property (p_legal_pattern) else $error("bad segment pattern");
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule

bind sds_scanner sds_scanner_props #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES), .SCAN_CYCLES(SCAN_CYCLES)) u_props (
  .clock_i(clock_i), .srst_i(srst_i), .conv_done_i(conv_done_i), .conversion_result_i(conversion_result_i),
  .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .display_value_o(display_value_o),
  .digit_select_bit0_o(digit_select_bit0_o), .digit_select_bit1_o(digit_select_bit1_o),
  .segment_line_o(segment_line_o));

// *** tb/sds_conv_model.sv ***
// Converter model standing at the scanner's far side
`timescale 1ns/1ns
module sds_conv_model (
  input  wire logic        clock_i,        // System clock
  input  wire logic        srst_i,         // Synchronous reset
  input  wire logic        conv_start_i,   // Start pulse
  input  wire logic [2:0]  conv_channel_i, // Channel select
  input  wire logic [9:0]  code_i,         // Sensor code on channel zero
  input  wire logic [7:0]  delay_i,        // Conversion time in cycles
  output logic             conv_done_o,    // Result ready level
  output logic [15:0]      result_o        // Left-aligned result
);
  logic [7:0] left;
  logic       busy;
  // ****************************************************************
  // Conversion; result toggles while not valid so no stale value passes
  // ****************************************************************
  always @(posedge clock_i) begin
    if (srst_i) begin
      conv_done_o <= 1'b0;
      busy        <= 1'b0;
      left        <= 8'h00;
      result_o    <= 16'h5a5a;
    end else if (conv_start_i) begin
      conv_done_o <= 1'b0;
      busy        <= 1'b1;
      left        <= delay_i;
      result_o    <= ~result_o;
    end else if (busy && left == 8'h00) begin
      busy        <= 1'b0;
      conv_done_o <= 1'b1;
      result_o    <= {(conv_channel_i == 3'h0) ? code_i : ~code_i, 6'h00};
    end else begin
      left <= busy ? left - 8'h01 : left;
      if (!conv_done_o) begin
        result_o <= ~result_o;
      end
    end
  end
endmodule

// *** tb/sds_scanner_test.sv ***
// Self-checking testbench for the sensor display scanner
`timescale 1ns/1ns
module sds_scanner_test;
  logic        clock_i;
  logic        srst_i;
  logic        conv_done_i;
  logic [15:0] conversion_result_i;
  logic        conv_start_o;
  logic [2:0]  conv_channel_o;
  logic [10:0] display_value_o;
  logic        bit0;
  logic        bit1;
  logic [7:0]  segment_line_o;
  logic [1:0]  sel;
  logic [1:0]  last;
  logic [1:0]  nxt;
  logic [9:0]  code;
  logic [7:0]  delay;
  logic [9:0]  corner [0:2];
  int          errors;
  int          total_checks;
  int          n;
  assign sel = {bit1, bit0};
  // Short counts keep a sample period at 960 cycles
  sds_scanner #(.BASE_TICK_CYCLES(32'd64), .SCAN_CYCLES(32'd16)) DUT (
    .clock_i(clock_i), .srst_i(srst_i), .conv_done_i(conv_done_i), .conversion_result_i(conversion_result_i),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .display_value_o(display_value_o),
    .digit_select_bit0_o(bit0), .digit_select_bit1_o(bit1), .segment_line_o(segment_line_o));
  sds_conv_model u_conv (
    .clock_i(clock_i), .srst_i(srst_i), .conv_start_i(conv_start_o), .conv_channel_i(conv_channel_o),
    .code_i(code), .delay_i(delay), .conv_done_o(conv_done_i), .result_o(conversion_result_i));
  // ****************************************************************
  // Expectations and reporting
  // ****************************************************************
  function automatic int exp_val(input int c);
    return (10000 * c + 971850) / 9207;
  endfunction
  function automatic logic [7:0] exp_pat(input int v, input int place);
    logic [7:0] t [0:9];
    int d;
    t = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27, 8'h7f, 8'h6f};
    d = (place == 0) ? v % 10 : (place == 1) ? v / 10 % 10 : (place == 2) ? v / 100 % 10 : v / 1000 % 10;
    if ((place == 2 && v < 100) || (place == 3 && v < 1000)) begin
      return 8'h00;
    end
    return (place == 1) ? (t[d] | 8'h80) : t[d];
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    repeat (15000) @(posedge clock_i);
    errors++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence: corner codes, then random ones, prompt and slow
  // ****************************************************************
  initial begin
    srst_i = 1'b1;
    code = 10'h000;
    delay = 8'd5;
    errors = 0;
    total_checks = 0;
    corner = '{10'h000, 10'h3ff, 10'h20b};
    void'($urandom(32'h23fb));
    repeat (12) @(posedge clock_i);
    @(negedge clock_i) srst_i = 1'b0;
    @(negedge clock_i);
    check("select", {14'h0, sel}, 16'h0);
    check("segments", {8'h0, segment_line_o}, 16'h0);
    for (int i = 0; i < 6; i++) begin
      @(negedge clock_i);
      code = (i < 3) ? corner[i] : 10'($urandom % 1024);
      delay = (i % 2) ? 8'd100 : 8'd5;
      n = 0;
      while (conv_start_o !== 1'b1 && n < 2000) begin
        @(negedge clock_i);
        n++;
      end
      check("start seen", {15'h0, conv_start_o}, 16'h1);
      repeat (200) @(negedge clock_i);
      check("display value", {5'h0, display_value_o}, 16'(exp_val(code)));
      check("channel", {13'h0, conv_channel_o}, 16'h0);
      for (int j = 0; j < 5; j++) begin
        last = sel;
        nxt = last + 2'h1;
        n = 0;
        while (sel === last && n < 40) begin
          @(negedge clock_i);
          n++;
        end
        check("select step", {14'h0, sel}, {14'h0, nxt});
        check("segments", {8'h0, segment_line_o}, {8'h0, exp_pat(exp_val(code), nxt)});
      end
    end
    stop_test();
  end
endmodule
